/* File: rtl/sdss_consts.vh */
`ifndef SDSS_CONSTS_VH
`define SDSS_CONSTS_VH

// Register byte offsets
`define SDSS_OFS_SWITCH   4'h0
`define SDSS_OFS_COMMAND  4'h4
`define SDSS_OFS_STATUS   4'h8
`define SDSS_OFS_EVENT    4'hC

// Direct-control command window
`define SDSS_CMD_FIRST    8'h20
`define SDSS_CMD_LAST     8'h2F
`define SDSS_CMD_OUT_JUMP 8'h28

// Switch vector bit positions
`define SDSS_SW_TRACK     0
`define SDSS_SW_SLED      1
`define SDSS_SW_JUMP_POS  2
`define SDSS_SW_JUMP_NEG  3
`define SDSS_SW_KICK_POS  4
`define SDSS_SW_KICK_NEG  5
`define SDSS_SW_WIDTH     6

// Status field positions
`define SDSS_ST_PHASE_LO  8
`define SDSS_ST_PHASE_HI  9
`define SDSS_ST_PIN       12
`define SDSS_ST_TZC       13

// Event field positions
`define SDSS_EV_TZC_RISE  0
`define SDSS_EV_TZC_FALL  1
`define SDSS_EV_REJECT    2

// Reset values
`define SDSS_SW_RESET     6'h00
`define SDSS_CMD_RESET    8'h00

// Synchroniser depth
`define SDSS_SYNC_STAGES  2

// Cycles from reset release until the zero-cross edge history is valid
`define SDSS_PRIME_COUNT  2'h3

`endif

/* File: rtl/sdss_sync.v */
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for one pin; first stage feeds only the second
module sdss_sync (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Asynchronous pin in, synchronised level out
	input  wire async_i,
	output wire sync_o
);

	reg stage_one;
	reg stage_two;

	// Metastability filter
	always @(posedge clk_i) begin
		if (rst_i) begin
			stage_one <= 1'b0;
			stage_two <= 1'b0;
		end else begin
			stage_one <= async_i;
			stage_two <= stage_one;
		end
	end

	assign sync_o = stage_two;

endmodule // sdss_sync

`default_nettype wire

/* File: rtl/sdss_preset.v */
`timescale 1ns/10ps
`default_nettype none
`include "sdss_consts.vh"

// Preset switch sets for the three direct-control phases.
// Bit order: track, sled, jump+, jump-, kick+, kick-.
module sdss_preset (
	// Low nibble of the loaded command
	input  wire [3:0] index_i,
	// Switch sets for each phase
	output reg  [5:0] phase_one_o,
	output reg  [5:0] phase_two_o,
	output reg  [5:0] phase_three_o
);

	// Loops closed again after a move with an even command nibble
	localparam [5:0] SDSS_LOOPS_ON = 6'h03;

	// Table decode; index bit 3 picks jump versus sled kick
	always @* begin
		phase_one_o   = SDSS_LOOPS_ON;
		phase_two_o   = SDSS_LOOPS_ON;
		phase_three_o = index_i[0] ? 6'h02 : SDSS_LOOPS_ON;
		if (index_i[3]) begin
			// Outward jump accelerates negative, brakes positive
			if (!index_i[2]) begin
				phase_one_o = 6'h0A;
				phase_two_o = 6'h06;
			end else begin
				phase_one_o = 6'h06;
				phase_two_o = 6'h0A;
			end
		end else begin
			// Sled kick then counter kick, tracking left open
			if (!index_i[0]) begin
				phase_one_o = 6'h10;
				phase_two_o = 6'h20;
			end else begin
				phase_one_o = 6'h20;
				phase_two_o = 6'h10;
			end
		end
	end

endmodule // sdss_preset

`default_nettype wire

/* File: rtl/sdss_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "sdss_consts.vh"

module sdss_top (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [3:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Pins from the drive controller and comparator
	input  wire        direct_control_pin_i,
	input  wire        track_zero_cross_i,
	// Switch drives
	output wire        tracking_loop_switch_o,
	output wire        sled_loop_switch_o,
	output wire        jump_positive_current_switch_o,
	output wire        jump_negative_current_switch_o,
	output wire        sled_kick_positive_switch_o,
	output wire        sled_kick_negative_switch_o,
	// Binarised tracking error, synchronised
	output wire        track_zero_cross_o
);

	// Sequencer phases. The code doubles as the phase field of the
	// status word, so software reads the same numbers as the table.
	// IDLE ignores the pin; PH3 holds its set until the next command or switch write,
	// which keeps a late pin edge from undoing a finished move.
	localparam [1:0] SDSS_IDLE = 2'b00;
	localparam [1:0] SDSS_PH1  = 2'b01;
	localparam [1:0] SDSS_PH2  = 2'b10;
	localparam [1:0] SDSS_PH3  = 2'b11;

	// Switch state and sequencer
	reg  [5:0]  sw;
	reg  [5:0]  next_sw;
	reg  [1:0]  phase;
	reg  [1:0]  next_phase;
	// Command and event registers
	reg  [3:0]  cmd_index;
	reg  [7:0]  last_cmd;
	reg         tzc_prev;
	reg  [2:0]  events;
	reg  [2:0]  next_events;
	reg  [31:0] next_dat;
	reg  [1:0]  prime_cnt;
	// Synchronised pins and preset table
	wire        pin_level;
	wire        tzc_level;
	wire [5:0]  preset_one;
	wire [5:0]  preset_two;
	wire [5:0]  preset_three;
	wire [3:0]  preset_index;
	// Bus decode and command qualification
	wire        bus_req;
	wire        bus_wr;
	wire        wr_switch;
	wire        wr_command;
	wire        wr_event;
	wire        cmd_in_window;
	wire        cmd_accept;
	wire        cmd_reject;
	// Zero-cross edges and start-up hold-off
	wire        prime_done;
	wire        tzc_rise;
	wire        tzc_fall;

	// Both pins are asynchronous to clk_i;
	// each passes two flops before any logic reads it
	sdss_sync u_pin_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (direct_control_pin_i),
		.sync_o  (pin_level)
	);

	sdss_sync u_tzc_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (track_zero_cross_i),
		.sync_o  (tzc_level)
	);

	// Preset table follows the loaded command. The byte being accepted
	// selects its own phase one set, which the index register would
	// only deliver a cycle late, so the index bypasses the register
	// on the accepting cycle.
	assign preset_index = cmd_accept ? dat_i[3:0] : cmd_index;

	sdss_preset u_preset (
		.index_i       (preset_index),
		.phase_one_o   (preset_one),
		.phase_two_o   (preset_two),
		.phase_three_o (preset_three)
	);

	// Bus decode; ack after one wait, dropped the cycle after.
	// Masking the request with ack_o keeps a master that holds stb
	// high through the ack cycle from being taken twice.
	assign bus_req    = cyc_i & stb_i & ~ack_o;
	assign bus_wr     = bus_req & we_i;
	assign wr_switch  = bus_wr & sel_i[0] & (adr_i == `SDSS_OFS_SWITCH);
	assign wr_command = bus_wr & sel_i[0] & (adr_i == `SDSS_OFS_COMMAND);
	assign wr_event   = bus_wr & sel_i[0] & (adr_i == `SDSS_OFS_EVENT);

	// Command window check, range 20h..2Fh. The pin level is the
	// synchronised one, so the pin must be high two cycles ahead of
	// the write for the command to be taken.
	assign cmd_in_window = (dat_i[7:0] >= `SDSS_CMD_FIRST) &&
		(dat_i[7:0] <= `SDSS_CMD_LAST);
	assign cmd_accept = wr_command & cmd_in_window & pin_level;
	// A window command with the pin low loads only last_cmd; like a byte
	// outside the window it only raises the reject event
	assign cmd_reject = wr_command & ~(cmd_in_window & pin_level);

	// Zero-cross edges read the second stage only. Edges are held off
	// until the synchroniser and tzc_prev hold real pin samples, else
	// a comparator idling high would log a false rise after reset.
	assign prime_done = (prime_cnt == `SDSS_PRIME_COUNT);
	assign tzc_rise   = prime_done & tzc_level & ~tzc_prev;
	assign tzc_fall   = prime_done & ~tzc_level & tzc_prev;

	// Start-up hold-off counter; it stops once the pipeline is full,
	// so it costs nothing after the first few cycles
	always @(posedge clk_i) begin
		if (rst_i) begin
			prime_cnt <= 2'h0;
		end else if (!prime_done) begin
			prime_cnt <= prime_cnt + 2'h1;
		end
	end

	// Sequencer and manual switch control. A command wins over a switch
	// write in the same cycle; a switch write hands control back to
	// software and leaves the pin without effect.
	always @* begin
		next_sw    = sw;
		next_phase = phase;
		if (cmd_accept) begin
			next_sw    = preset_one;
			next_phase = SDSS_PH1;
		end else if (wr_switch) begin
			// Manual write leaves pin control
			next_sw    = dat_i[5:0];
			next_phase = SDSS_IDLE;
		end else begin
			case (phase)
				SDSS_IDLE: begin
					// Pin ignored until a command is taken
					next_phase = SDSS_IDLE;
				end
				SDSS_PH1: begin
					// Pin low starts the second phase
					if (!pin_level) begin
						next_sw    = preset_two;
						next_phase = SDSS_PH2;
					end
				end
				SDSS_PH2: begin
					// Pin high again ends on the third set
					if (pin_level) begin
						next_sw    = preset_three;
						next_phase = SDSS_PH3;
					end
				end
				SDSS_PH3: begin
					// Final set holds until a new command or a switch write
					next_phase = SDSS_PH3;
				end
				default: begin
					// Unused code falls back to idle
					next_phase = SDSS_IDLE;
				end
			endcase
		end
	end

	// Sticky events; a new event wins over a same-cycle clear
	always @* begin
		next_events = events;
		// Write one to clear; the set terms below override it
		if (wr_event) begin
			next_events = events & ~dat_i[2:0];
		end
		if (tzc_rise) begin
			next_events[`SDSS_EV_TZC_RISE] = 1'b1;
		end
		if (tzc_fall) begin
			next_events[`SDSS_EV_TZC_FALL] = 1'b1;
		end
		// Rejected commands are flagged so software can retry
		if (cmd_reject) begin
			next_events[`SDSS_EV_REJECT] = 1'b1;
		end
	end

	// Read data mux; unmapped words read zero
	// and unused upper bits of every word read zero too
	always @* begin
		next_dat = 32'h00000000;
		case (adr_i)
			`SDSS_OFS_SWITCH: begin
				// Switch word as written or as preset
				next_dat[5:0] = sw;
			end
			`SDSS_OFS_COMMAND: begin
				// Last byte written, taken or not
				next_dat[7:0] = last_cmd;
			end
			`SDSS_OFS_STATUS: begin
				next_dat[5:0] = sw;
				next_dat[`SDSS_ST_PHASE_HI:`SDSS_ST_PHASE_LO] = phase;
				// Live pin levels as the sequencer sees them
				next_dat[`SDSS_ST_PIN] = pin_level;
				next_dat[`SDSS_ST_TZC] = tzc_level;
			end
			`SDSS_OFS_EVENT: begin
				// Sticky flags, cleared by writing ones
				next_dat[2:0] = events;
			end
			default: begin
				next_dat = 32'h00000000;
			end
		endcase
	end

	// Switch state and sequencer phase; the switches drive the analog
	// side directly, so they change in this process only
	always @(posedge clk_i) begin
		if (rst_i) begin
			sw    <= `SDSS_SW_RESET;
			phase <= SDSS_IDLE;
		end else begin
			sw    <= next_sw;
			phase <= next_phase;
		end
	end

	// Command bytes; the index only follows accepted commands so that
	// a rejected byte cannot disturb a sequence already running
	always @(posedge clk_i) begin
		if (rst_i) begin
			cmd_index <= 4'h0;
			last_cmd  <= `SDSS_CMD_RESET;
		end else begin
			if (wr_command) begin
				last_cmd <= dat_i[7:0];
			end
			if (cmd_accept) begin
				cmd_index <= dat_i[3:0];
			end
		end
	end

	// Edge history and sticky events
	always @(posedge clk_i) begin
		if (rst_i) begin
			tzc_prev <= 1'b0;
			events   <= 3'h0;
		end else begin
			tzc_prev <= tzc_level;
			events   <= next_events;
		end
	end

	// Acknowledge, one cycle per taken request
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_req;
		end
	end

	// Read data stands only with ack and is zero otherwise,
	// so a stale word is never seen between answers
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else begin
			dat_o <= bus_req ? next_dat : 32'h00000000;
		end
	end

	// Switch drives straight from the state register,
	// so no decode glitch reaches the analog switches
	assign tracking_loop_switch_o         = sw[`SDSS_SW_TRACK];
	assign sled_loop_switch_o             = sw[`SDSS_SW_SLED];
	assign jump_positive_current_switch_o = sw[`SDSS_SW_JUMP_POS];
	assign jump_negative_current_switch_o = sw[`SDSS_SW_JUMP_NEG];
	assign sled_kick_positive_switch_o    = sw[`SDSS_SW_KICK_POS];
	assign sled_kick_negative_switch_o    = sw[`SDSS_SW_KICK_NEG];
	assign track_zero_cross_o             = tzc_level;

endmodule // sdss_top

`default_nettype wire

/* File: verif/sdss_exp.svh */
// Expected switch set for a command nibble in a given phase
function automatic logic [5:0] sdss_pre(input logic [3:0] i, input int ph);
	case (ph)
		1: return i[3] ? (i[2] ? 6'h06 : 6'h0A) : (i[0] ? 6'h20 : 6'h10);
		2: return i[3] ? (i[2] ? 6'h0A : 6'h06) : (i[0] ? 6'h10 : 6'h20);
		default: return i[0] ? 6'h02 : 6'h03;
	endcase
endfunction

/* File: verif/sdss_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module sdss_top_asserts (
	input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
	input wire logic [3:0]  adr_i, sel_i,
	input wire logic [31:0] dat_i, dat_o,
	input wire logic        direct_control_pin_i, track_zero_cross_i,
	input wire logic        track_zero_cross_o, tracking_loop_switch_o,
	input wire logic        sled_loop_switch_o, jump_positive_current_switch_o,
	input wire logic        jump_negative_current_switch_o,
	input wire logic        sled_kick_positive_switch_o,
	input wire logic        sled_kick_negative_switch_o
);
`include "sdss_exp.svh"
	// Switch vector in register bit order
	wire logic [5:0] sw = {sled_kick_negative_switch_o,
		sled_kick_positive_switch_o, jump_negative_current_switch_o,
		jump_positive_current_switch_o, sled_loop_switch_o,
		tracking_loop_switch_o};
	wire logic pin = direct_control_pin_i;
	wire logic tk = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
	logic arm;
	logic [3:0] idx;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Loaded command; pin must be settled high, else outcome is ambiguous
	always_ff @(posedge clk_i) begin
		if (rst_i)
			arm <= 1'h0;
		else if (tk && adr_i == 4'h0)
			arm <= 1'h0;
		else if (tk && adr_i == 4'h4 && dat_i[7:4] == 4'h2 && pin
			&& $past(pin) && $past(pin, 2)) begin
			arm <= 1'h1;
			idx <= dat_i[3:0];
		end
	end
	property p_wr; tk && adr_i == 4'h0 |=> sw == $past(dat_i[5:0]); endproperty
	a_wr: assert property (p_wr) else $error("switch write lost");
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat: assert property (p_dat) else $error("read data outside ack");
	property p_cmd; tk && adr_i == 4'h4 && dat_i[7:4] == 4'h2 && pin
		&& $past(pin) && $past(pin, 2)
		|=> sw == sdss_pre($past(dat_i[3:0]), 1); endproperty
	a_cmd: assert property (p_cmd) else $error("phase one wrong");
	property p_two; arm && sw == sdss_pre(idx, 1) && $fell(pin)
		|-> ##[2:4] sw == sdss_pre(idx, 2); endproperty
	a_two: assert property (p_two) else $error("phase two wrong");
	property p_three; arm && sw == sdss_pre(idx, 2) && $rose(pin)
		|-> ##[2:4] sw == sdss_pre(idx, 3); endproperty
	a_three: assert property (p_three) else $error("phase three wrong");
	property p_hold; !arm && !(cyc_i && stb_i && we_i) |=> $stable(sw);
	endproperty
	a_hold: assert property (p_hold) else $error("switches moved idle");
	property p_tzc; !$past(rst_i) && !$past(rst_i, 2)
		|-> track_zero_cross_o == $past(track_zero_cross_i, 2); endproperty
	a_tzc: assert property (p_tzc) else $error("zero cross copy wrong");
endmodule // sdss_top_asserts
`default_nettype wire

/* File: verif/sdss_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Controller side: lowers the pin on the jump edge, raises it after settling
module sdss_host #(parameter int SETTLE = 8) (
	input wire logic clk_i, go_i, outward_i, tzc_i,
	output var logic pin_o
);
	logic tzc_q;
	int cnt;
	initial begin
		pin_o = 1'h1;
		tzc_q = 1'h0;
		cnt = 0;
	end
	// Inward waits for a rising cross, outward for a falling one
	always @(posedge clk_i) begin
		tzc_q <= tzc_i;
		if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 1)
				pin_o <= 1'h1;
		end else if (go_i && (outward_i ? tzc_q && !tzc_i : !tzc_q && tzc_i)) begin
			pin_o <= 1'h0;
			cnt <= SETTLE;
		end
	end
endmodule // sdss_host
`default_nettype wire

/* File: verif/sdss_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sdss_top_tb;
`include "sdss_exp.svh"
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, rd;
	logic track_zero_cross = 1'h0, go = 1'h0, outw = 1'h0;
	wire [31:0] dat_o;
	wire ack_o, pin, tzc_o;
	wire [5:0] sw;
	int errors = 0, cmp_count = 0;
	always #10 clk_i = ~clk_i;
	sdss_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .direct_control_pin_i(pin),
		.track_zero_cross_i(track_zero_cross), .tracking_loop_switch_o(sw[0]),
		.sled_loop_switch_o(sw[1]), .jump_positive_current_switch_o(sw[2]),
		.jump_negative_current_switch_o(sw[3]),
		.sled_kick_positive_switch_o(sw[4]),
		.sled_kick_negative_switch_o(sw[5]), .track_zero_cross_o(tzc_o));
	sdss_host #(.SETTLE(8)) host (.clk_i(clk_i), .go_i(go), .outward_i(outw),
		.tzc_i(tzc_o), .pin_o(pin));
	task automatic conclude;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	// One classic cycle; ack and read data taken at the same edge
	task automatic wb(input logic w, input logic [3:0] a, s,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 20);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
		if (n >= 20) begin
			chk("ack", 1, 0);
			conclude();
		end
	endtask
	task automatic await_pin(input logic lv);
		int n;
		for (n = 0; pin !== lv && n < 60; n++)
			@(posedge clk_i);
		if (pin !== lv) begin
			chk("pin", lv, pin);
			conclude();
		end
	endtask
	task automatic t_sw;
		for (int i = 0; i < 6; i++) begin
			wb(1'h1, 4'h0, 4'hF, 32'h1 << i);
			chk("sw", 32'h1 << i, sw);
			wb(1'h0, 4'h0, 4'hF, 32'h0);
			chk("sw rd", 32'h1 << i, rd);
		end
	endtask
	// Idle pin activity, masked lane and bad command leave switches alone
	task automatic t_hold;
		wb(1'h1, 4'h0, 4'hF, 32'h15);
		wb(1'h1, 4'h0, 4'hE, 32'h2A);
		wb(1'h1, 4'h4, 4'hF, 32'h30);
		wb(1'h0, 4'h6, 4'hF, 32'h0);
		chk("unmapped", 0, rd);
		wb(1'h0, 4'hC, 4'hF, 32'h0);
		chk("event rej", 32'h4, rd);
		wb(1'h0, 4'h4, 4'hF, 32'h0);
		chk("command", 32'h30, rd);
		outw <= 1'h0;
		go <= 1'h1;
		repeat (4) @(posedge clk_i);
		track_zero_cross <= 1'h1;
		await_pin(1'h0);
		go <= 1'h0;
		await_pin(1'h1);
		repeat (5) @(posedge clk_i);
		chk("hold", 32'h15, sw);
		wb(1'h0, 4'hC, 4'hF, 32'h0);
		chk("event rise", 32'h5, rd);
		wb(1'h1, 4'hC, 4'hF, 32'h7);
		wb(1'h0, 4'hC, 4'hF, 32'h0);
		chk("event clr", 32'h0, rd);
	endtask
	task automatic t_jump(input logic [7:0] c);
		logic [13:0] st;
		wb(1'h1, 4'h0, 4'hF, 32'h0);
		outw <= (c == 8'h28);
		track_zero_cross <= (c == 8'h28);
		repeat (4) @(posedge clk_i);
		chk("tzc", track_zero_cross, tzc_o);
		wb(1'h1, 4'h4, 4'hF, {24'h0, c});
		chk("one", sdss_pre(c[3:0], 1), sw);
		go <= 1'h1;
		track_zero_cross <= ~track_zero_cross;
		await_pin(1'h0);
		go <= 1'h0;
		repeat (5) @(posedge clk_i);
		chk("two", sdss_pre(c[3:0], 2), sw);
		await_pin(1'h1);
		repeat (5) @(posedge clk_i);
		chk("three", sdss_pre(c[3:0], 3), sw);
		wb(1'h0, 4'h8, 4'hF, 32'h0);
		st = {track_zero_cross, 1'h1, 2'h0, 2'h3, 2'h0, sdss_pre(c[3:0], 3)};
		chk("status", st, rd[13:0]);
	endtask
	// Mid-run reset clears switches; a high comparator logs no edge
	task automatic t_rst;
		wb(1'h1, 4'h0, 4'hF, 32'h3F);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		chk("reset sw", 32'h0, sw);
		repeat (6) @(posedge clk_i);
		wb(1'h0, 4'hC, 4'hF, 32'h0);
		chk("reset event", 32'h0, rd);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		chk("init sw", 32'h0, sw);
		t_sw();
		t_hold();
		for (int c = 32; c < 48; c++)
			t_jump(c[7:0]);
		t_rst();
		conclude();
	end
endmodule // sdss_top_tb
bind sdss_top sdss_top_asserts u_chk (.*);
`default_nettype wire
